// ==== shared/ccv_defs.svh ====
`ifndef CCV_DEFS_SVH
`define CCV_DEFS_SVH

// command message layout, most significant bit sent first
`define CCV_MSG_LEN      16
`define CCV_CNT_W        5
`define CCV_CNT_MAX      5'h11
`define CCV_HDR_HI       15
`define CCV_HDR_LO       12
`define CCV_ID_HI        11
`define CCV_ID_LO        8
`define CCV_CMD_BIT      7
`define CCV_CMDN_BIT     6
`define CCV_RSV_HI       5
`define CCV_CMD_HDR      4'ha
`define CCV_RSV_VAL      6'h00

// feedback message layout
`define CCV_FB_HDR       4'h5
`define CCV_FB_GAP       5'h10
`define CCV_FB_PAD       10'h000

`endif

// ==== shared/ccv_pkg.sv ====
package ccv_pkg;

    typedef enum logic [1:0] {
        CCV_RX_IDLE = 2'b01,
        CCV_RX_BUSY = 2'b10
    } ccv_rx_state_t;

endpackage : ccv_pkg

// ==== design/ccv_component_command_voter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccv_defs.svh"

module ccv_component_command_voter #(
    parameter logic [3:0] COMP_ID = 4'h0  // component address, value arbitrary
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [1:0] cmd_frame_i,
    input  wire logic [1:0] cmd_data_i,
    input  wire logic       dual_mode_i,
    input  wire logic [1:0] chan_bypass_i,
    input  wire logic       comp_status_i,
    output logic            comp_cmd_o,
    output logic [1:0]      fb_frame_o,
    output logic [1:0]      fb_data_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] frame_m_r, frame_s_r, frame_d_r;
    logic [1:0] data_m_r,  data_s_r;
    logic       dual_m_r,  dual_s_r;
    logic [1:0] byp_m_r,   byp_s_r;
    logic       stat_m_r,  stat_s_r;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            frame_m_r <= 2'h0;
            frame_s_r <= 2'h0;
            frame_d_r <= 2'h0;
            data_m_r  <= 2'h0;
            data_s_r  <= 2'h0;
            dual_m_r  <= 1'h0;
            dual_s_r  <= 1'h0;
            byp_m_r   <= 2'h0;
            byp_s_r   <= 2'h0;
            stat_m_r  <= 1'h0;
            stat_s_r  <= 1'h0;
        end else begin
            frame_m_r <= cmd_frame_i;
            frame_s_r <= frame_m_r;
            frame_d_r <= frame_s_r;
            data_m_r  <= cmd_data_i;
            data_s_r  <= data_m_r;
            dual_m_r  <= dual_mode_i;
            dual_s_r  <= dual_m_r;
            byp_m_r   <= chan_bypass_i;
            byp_s_r   <= byp_m_r;
            stat_m_r  <= comp_status_i;
            stat_s_r  <= stat_m_r;
        end
    end

    // ------------------------------------------------------------
    // command receivers, one per channel
    // ------------------------------------------------------------
    logic [1:0] chan_valid;
    logic [1:0] chan_cmd;
    logic [1:0] msg_done;
    logic [1:0] msg_good;

    for (genvar g = 0; g < 2; g++) begin : g_rx
        ccv_pkg::ccv_rx_state_t          state_r, state_nxt;
        logic [`CCV_MSG_LEN-1:0]         sreg_r,  sreg_nxt;
        logic [`CCV_CNT_W-1:0]           cnt_r,   cnt_nxt;
        logic                            val_r,   val_nxt;
        logic                            cmd_r,   cmd_nxt;
        logic                            done;
        logic                            good;

        // a frame ends on the falling edge of the synchronised frame line
        assign done = frame_d_r[g] & ~frame_s_r[g];
        assign good = (cnt_r == 5'(`CCV_MSG_LEN))
                    & (sreg_r[`CCV_HDR_HI:`CCV_HDR_LO] == `CCV_CMD_HDR)
                    & (sreg_r[`CCV_ID_HI:`CCV_ID_LO] == COMP_ID)
                    & (sreg_r[`CCV_CMD_BIT] != sreg_r[`CCV_CMDN_BIT])
                    & (sreg_r[`CCV_RSV_HI:0] == `CCV_RSV_VAL);

        always_comb begin
            state_nxt = state_r;
            sreg_nxt  = sreg_r;
            cnt_nxt   = cnt_r;
            val_nxt   = val_r;
            cmd_nxt   = cmd_r;
            case (state_r)
                ccv_pkg::CCV_RX_IDLE: begin
                    if (frame_s_r[g]) begin
                        state_nxt = ccv_pkg::CCV_RX_BUSY;
                        sreg_nxt  = {sreg_r[`CCV_MSG_LEN-2:0], data_s_r[g]};
                        cnt_nxt   = 5'h01;
                    end
                end
                ccv_pkg::CCV_RX_BUSY: begin
                    if (frame_s_r[g]) begin
                        sreg_nxt = {sreg_r[`CCV_MSG_LEN-2:0], data_s_r[g]};
                        if (cnt_r != `CCV_CNT_MAX) begin
                            cnt_nxt = cnt_r + 5'h01;  // saturates: overlong stays bad
                        end
                    end else begin
                        state_nxt = ccv_pkg::CCV_RX_IDLE;
                        if (good) begin
                            val_nxt = 1'b1;
                            cmd_nxt = sreg_r[`CCV_CMD_BIT];
                        end
                    end
                end
                default: begin
                    state_nxt = ccv_pkg::CCV_RX_IDLE;
                end
            endcase
        end

        always_ff @(posedge core_clk_i) begin
            if (!reset_n_i) begin
                state_r <= ccv_pkg::CCV_RX_IDLE;
                sreg_r  <= '0;
                cnt_r   <= '0;
                val_r   <= 1'b0;
                cmd_r   <= 1'b0;
            end else begin
                state_r <= state_nxt;
                sreg_r  <= sreg_nxt;
                cnt_r   <= cnt_nxt;
                val_r   <= val_nxt;
                cmd_r   <= cmd_nxt;
            end
        end

        assign chan_valid[g] = val_r;
        assign chan_cmd[g]   = cmd_r;
        assign msg_done[g]   = done & (state_r == ccv_pkg::CCV_RX_BUSY);
        assign msg_good[g]   = good;
    end

    // ------------------------------------------------------------
    // coincidence vote
    // ------------------------------------------------------------
    logic [1:0] act;
    logic       cmd_r, cmd_nxt;

    assign act = chan_valid & chan_cmd;

    always_comb begin
        cmd_nxt = 1'b0;
        if (!dual_s_r) begin
            cmd_nxt = act[0];
        end else begin
            case (byp_s_r)
                2'b00:   cmd_nxt = act[0] & act[1];
                2'b01:   cmd_nxt = act[1];
                2'b10:   cmd_nxt = act[0];
                default: cmd_nxt = 1'b0;  // both bypassed: fail safe off
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cmd_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    assign comp_cmd_o = cmd_r;

    // ------------------------------------------------------------
    // status feedback transmitter
    // ------------------------------------------------------------
    logic [`CCV_MSG_LEN-1:0] tx_sreg_r, tx_sreg_nxt;
    logic [`CCV_CNT_W-1:0]   tx_cnt_r,  tx_cnt_nxt;
    logic [1:0]              tx_en;
    logic [1:0]              fbf_r, fbf_nxt;
    logic [1:0]              fbd_r, fbd_nxt;

    // both channels carry status in dual mode, channel 0 only otherwise
    assign tx_en = {dual_s_r, 1'b1};

    always_comb begin
        tx_sreg_nxt = {tx_sreg_r[`CCV_MSG_LEN-2:0], 1'b0};
        tx_cnt_nxt  = tx_cnt_r + 5'h01;
        if (tx_cnt_r == `CCV_FB_GAP) begin
            tx_cnt_nxt  = 5'h00;
            tx_sreg_nxt = {`CCV_FB_HDR, stat_s_r, ~stat_s_r, `CCV_FB_PAD};
        end
        if (tx_cnt_r < `CCV_FB_GAP) begin
            fbf_nxt = tx_en;
            fbd_nxt = tx_en & {2{tx_sreg_r[`CCV_MSG_LEN-1]}};
        end else begin
            fbf_nxt = 2'h0;
            fbd_nxt = 2'h0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            tx_sreg_r <= '0;
            tx_cnt_r  <= `CCV_FB_GAP;
            fbf_r     <= 2'h0;
            fbd_r     <= 2'h0;
        end else begin
            tx_sreg_r <= tx_sreg_nxt;
            tx_cnt_r  <= tx_cnt_nxt;
            fbf_r     <= fbf_nxt;
            fbd_r     <= fbd_nxt;
        end
    end

    assign fb_frame_o = fbf_r;
    assign fb_data_o  = fbd_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence good_msg_s(int i);
        msg_done[i] && msg_good[i];
    endsequence

    sequence bad_msg_s(int i);
        msg_done[i] && !msg_good[i];
    endsequence

    sequence fb_start_s;
        !fb_frame_o[0] ##1 fb_frame_o[0];
    endsequence

    coinc_dual_a: assert property (
        dual_s_r && byp_s_r == 2'b00 && !(act[0] && act[1]) |=> !comp_cmd_o)
        else $error("command without two-channel coincidence");

    coinc_both_a: assert property (
        dual_s_r && byp_s_r == 2'b00 && act[0] && act[1] |=> comp_cmd_o)
        else $error("coincident command not passed");

    bypass_one_a: assert property (
        dual_s_r && byp_s_r == 2'b01 && act[1] && !act[0] |=> comp_cmd_o)
        else $error("bypass did not fall back to channel one");

    single_pass_a: assert property (
        !dual_s_r && (act[0] != act[1]) |=> comp_cmd_o == $past(act[0]))
        else $error("single mode did not follow channel zero");

    fb_both_a: assert property (
        dual_s_r && $past(dual_s_r) |-> fb_frame_o[1] == fb_frame_o[0] && fb_data_o[1] == fb_data_o[0])
        else $error("feedback differs between controllers");

    bad_drop_a: assert property (
        bad_msg_s(0) |=> $stable(chan_valid[0]) && $stable(chan_cmd[0]))
        else $error("malformed message was used");

    good_take_a: assert property (
        good_msg_s(1) |=> chan_valid[1] ##1 chan_valid[1])
        else $error("well formed message not accepted");

    reset_hold_a: assert property (
        chan_valid == 2'b00 |=> !comp_cmd_o)
        else $error("command asserted before any valid message");

    fb_header_a: assert property (
        fb_start_s |-> !fb_data_o[0] ##1 fb_data_o[0] ##1 !fb_data_o[0] ##1 fb_data_o[0]
                       ##1 fb_data_o[0] == $past(stat_s_r, 6))
        else $error("feedback header or status bit wrong");

endmodule : ccv_component_command_voter

`default_nettype wire

// ==== verif/ccv_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccv_ctrl_model (
    input  wire logic       core_clk_i,
    output logic [1:0]      frame_o,
    output logic [1:0]      data_o
);
    initial begin
        frame_o = 2'h0;
        data_o  = 2'h0;
    end
    // one-way sender, msb first; no reply is ever awaited
    task automatic send(input int ch, input logic [16:0] w, input int len);
        for (int i = len - 1; i >= 0; i--) begin
            @(posedge core_clk_i);
            frame_o[ch] <= 1'b1;
            data_o[ch]  <= w[i];
        end
        @(posedge core_clk_i);
        frame_o[ch] <= 1'b0;
        data_o[ch]  <= ~w[0];
        repeat (3) @(posedge core_clk_i);
    endtask : send
endmodule : ccv_ctrl_model
`default_nettype wire

// ==== verif/tb_component_command_voter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccv_defs.svh"
module tb_component_command_voter;
    logic        core_clk_i;
    logic        reset_n_i;
    logic [1:0]  cmd_frame_i;
    logic [1:0]  cmd_data_i;
    logic        dual_mode_i;
    logic [1:0]  chan_bypass_i;
    logic        comp_status_i;
    logic        comp_cmd_o;
    logic [1:0]  fb_frame_o;
    logic [1:0]  fb_data_o;
    int          fail_count = 0;
    int          total_checks = 0;
    logic        exp_cmd_q[$];
    logic [15:0] exp_fb_q[$];
    int          fb_ch_q[$];
    logic [16:0] bad[6];
    event        cmd_ev;
    event        fb_ev;

    ccv_component_command_voter i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .cmd_frame_i(cmd_frame_i), .cmd_data_i(cmd_data_i), .dual_mode_i(dual_mode_i),
        .chan_bypass_i(chan_bypass_i), .comp_status_i(comp_status_i), .comp_cmd_o(comp_cmd_o),
        .fb_frame_o(fb_frame_o), .fb_data_o(fb_data_o));
    ccv_ctrl_model i_ctrl (.core_clk_i(core_clk_i), .frame_o(cmd_frame_i), .data_o(cmd_data_i));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic tally(input logic ok, input logic [15:0] e, input logic [15:0] a);
        total_checks++;
        if (!ok) begin
            fail_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : tally
    task automatic cmp_cmd(input logic e, input logic a);
        tally(a === e, {15'h0, e}, {15'h0, a});
    endtask : cmp_cmd
    task automatic cmp_fb(input logic [15:0] e, input logic [15:0] a);
        tally(a === e, e, a);
    endtask : cmp_fb
    task automatic summarize;
        $display("checks=%0d failures=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    function automatic logic [16:0] msg(input logic c);
        return {1'b0, `CCV_CMD_HDR, 4'h0, c, ~c, `CCV_RSV_VAL};
    endfunction : msg
    task automatic chk(input logic e);
        repeat (6) @(negedge core_clk_i);
        exp_cmd_q.push_back(e);
        ->cmd_ev;
    endtask : chk
    task automatic cmd(input int ch, input logic [16:0] w, input int len, input logic e);
        i_ctrl.send(ch, w, len);
        chk(e);
    endtask : cmd
    task automatic byp(input logic [1:0] b, input logic e);
        @(posedge core_clk_i);
        chan_bypass_i <= b;
        chk(e);
    endtask : byp
    task automatic fb(input int ch);
        logic s;
        s = 1'($urandom_range(1, 0));
        @(posedge core_clk_i);
        comp_status_i <= s;
        repeat (20) @(posedge core_clk_i);
        exp_fb_q.push_back({`CCV_FB_HDR, s, ~s, `CCV_FB_PAD});
        fb_ch_q.push_back(ch);
        ->fb_ev;
        repeat (40) @(posedge core_clk_i);
    endtask : fb

    always @(cmd_ev) cmp_cmd(exp_cmd_q.pop_front(), comp_cmd_o);
    always @(fb_ev) begin : fb_mon
        int          ch;
        logic [15:0] got;
        ch = fb_ch_q.pop_front();
        do @(negedge core_clk_i); while (fb_frame_o[ch] !== 1'b0);
        do @(negedge core_clk_i); while (fb_frame_o[ch] !== 1'b1);
        for (int i = 15; i >= 0; i--) begin
            got[i] = fb_data_o[ch];
            if (i > 0) @(negedge core_clk_i);
        end
        cmp_fb(exp_fb_q.pop_front(), got);
    end

    initial begin
        reset_n_i     = 1'b0;
        dual_mode_i   = 1'b0;
        chan_bypass_i = 2'h0;
        comp_status_i = 1'b0;
        void'($urandom(32'hcf50));
        repeat (16) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        chk(1'b0);
        cmd(0, msg(1'b1), 16, 1'b1);
        // malformed clear requests: short, long, header, id, complement, reserved
        bad = '{msg(1'b0), msg(1'b0) << 1, msg(1'b0) ^ 17'h08000, msg(1'b0) ^ 17'h00100,
                msg(1'b0) ^ 17'h00040, msg(1'b0) | {11'h0, 6'($urandom_range(63, 1))}};
        foreach (bad[i]) cmd(0, bad[i], (i == 0) ? 15 : (i == 1) ? 17 : 16, 1'b1);
        cmd(0, msg(1'b0), 16, 1'b0);
        cmd(1, msg(1'b1), 16, 1'b0);
        fb(0);
        @(posedge core_clk_i);
        dual_mode_i <= 1'b1;
        chk(1'b0);
        cmd(0, msg(1'b1), 16, 1'b1);
        cmd(1, msg(1'b0), 16, 1'b0);
        byp(2'h2, 1'b1);
        byp(2'h1, 1'b0);
        cmd(1, msg(1'b1), 16, 1'b1);
        cmd(0, msg(1'b0), 16, 1'b1);
        byp(2'h3, 1'b0);
        fb(0);
        fb(1);
        byp(2'h1, 1'b1);
        @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        chk(1'b0);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        summarize();
    end
endmodule : tb_component_command_voter
`default_nettype wire
